// ---- include/rate_ready_pkg.sv ----
// package for the sample-rate and sample-ready block
// assumes a 100 MHz system clock and a register port driven by the serial-bus front end
package rate_ready_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int RATE_SLOW_HZ = 100;
    localparam int RATE_FAST_HZ = 400;
    localparam int PERIOD_SLOW_CYC = CLK_HZ / RATE_SLOW_HZ;
    localparam int PERIOD_FAST_CYC = CLK_HZ / RATE_FAST_HZ;
    // host reading window ends this long before the next sample
    localparam int GEN_GUARD_US = 150;
    localparam int GEN_GUARD_CYC = (GEN_GUARD_US * (CLK_HZ / 1_000_000));
    // register addresses
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h20;
    localparam logic [7:0] ADDR_PIN_ROUTING = 8'h22;
    localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h27;
    localparam logic [7:0] ADDR_AXIS_X = 8'h29;
    localparam logic [7:0] ADDR_AXIS_Y = 8'h2b;
    localparam logic [7:0] ADDR_AXIS_Z = 8'h2d;
    // field positions
    localparam int RATE_SELECT_POS = 7;
    localparam int AXIS_EN_LSB = 0;
    localparam int PIN_A_LSB = 0;
    localparam int PIN_B_LSB = 3;
    localparam int READY_POS = 3;
    localparam int OVERRUN_POS = 7;
    // reset values
    localparam logic [7:0] CONTROL_ONE_RST = 8'h07;
    localparam logic [7:0] PIN_ROUTING_RST = 8'h00;
    // event pin function codes
    localparam logic [2:0] PIN_FN_SRC_ONE = 3'h1;
    localparam logic [2:0] PIN_FN_SRC_TWO = 3'h2;
    localparam logic [2:0] PIN_FN_SRC_OR = 3'h3;
    localparam logic [2:0] PIN_FN_READY = 3'h4;
endpackage

// ---- src/sample_fifo.sv ----
// fifo of sample words with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- src/event_pin_mux.sv ----
// selects one event pin's function from a three-bit code
// assumes interrupt sources arrive as synchronous levels
`timescale 1ns/1ns
module event_pin_mux
    import rate_ready_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // selection
    input wire logic [2:0] code,
    input wire logic ready,
    input wire logic src_one,
    input wire logic src_two,
    // pin
    output logic pin
);
    wire logic next_pin = (code == PIN_FN_READY) ? ready :
                          (code == PIN_FN_SRC_ONE) ? src_one :
                          (code == PIN_FN_SRC_TWO) ? src_two :
                          (code == PIN_FN_SRC_OR) ? (src_one | src_two) :
                          1'b0;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin <= 1'b0;
        end else begin
            pin <= next_pin;
        end
    end
endmodule

// ---- src/sample_rate_ready.sv ----
// sample-rate timing, sample-ready flag, overrun status and event pin routing
// assumes a serial front end giving a one-cycle register read/write port
//
// Function
// - rate bit picks 100 Hz or 400 Hz
// - reset clears rate bit: 100 Hz
// - ready falls after full read sequence
// - late host: samples overwritten, trigger unreliable
// - status records overrun of unread set
// - routing bits 2-0 pin a, 5-3 pin b
// - codes 100 ready, 001 src one, 010 src two
// - code 011 drives OR of sources
// - ready flag sits in status bit 3
// - ready set when new set exists
// - ready clears after all enabled axes read
`timescale 1ns/1ns
module sample_rate_ready
    import rate_ready_pkg::*;
#(
    parameter int SAMPLE_W = 8,
    parameter int FIFO_DEPTH = 16,
    parameter int PERIOD_SLOW = PERIOD_SLOW_CYC,
    parameter int PERIOD_FAST = PERIOD_FAST_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // sensing front end
    input wire logic [3*SAMPLE_W-1:0] sense_data,
    input wire logic [3*SAMPLE_W-1:0] unused_guard,
    // interrupt sources
    input wire logic src_one,
    input wire logic src_two,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // outputs
    output logic sample_strobe,
    output logic event_pin_a,
    output logic event_pin_b
);
    localparam int CW = $clog2(PERIOD_SLOW + 1);
    logic [7:0] control_one;
    logic [7:0] pin_routing_control;
    logic [CW-1:0] period_cnt;
    logic sample_ready_flag;
    logic overrun;
    logic [2:0] axis_read;
    logic [3*SAMPLE_W-1:0] held;
    logic fifo_out_valid;
    logic fifo_in_ready;
    logic [3*SAMPLE_W-1:0] fifo_out_data;

    wire rate_select_bit = control_one[RATE_SELECT_POS];
    wire [2:0] axis_en = control_one[AXIS_EN_LSB +: 3];
    wire [CW-1:0] period_last = rate_select_bit ? CW'(PERIOD_FAST - 1)
                                                : CW'(PERIOD_SLOW - 1);
    wire period_end = (period_cnt >= period_last);
    // a sample leaves the fifo the cycle after it enters and always overwrites the holding register
    wire load_set = fifo_out_valid;
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CONTROL_ONE);
    wire wr_route = reg_wr && (reg_addr == ADDR_PIN_ROUTING);

    function automatic logic [2:0] axis_hit(input logic [7:0] a);
        axis_hit = {a == ADDR_AXIS_Z, a == ADDR_AXIS_Y, a == ADDR_AXIS_X};
    endfunction

    wire [2:0] rd_hit = reg_rd ? axis_hit(reg_addr) : 3'h0;
    wire [2:0] next_axis_read = load_set ? 3'h0 : (axis_read | rd_hit);
    wire all_read = ((next_axis_read & axis_en) == axis_en) && (axis_en != 3'h0);

    sample_fifo #(
        .WIDTH(3*SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(sample_strobe),
        .in_ready(fifo_in_ready),
        .in_data(sense_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            control_one <= CONTROL_ONE_RST;
            pin_routing_control <= PIN_ROUTING_RST;
        end else begin
            if (wr_ctrl) begin
                control_one <= reg_wdata;
            end
            if (wr_route) begin
                pin_routing_control <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            period_cnt <= '0;
            sample_strobe <= 1'b0;
        end else begin
            period_cnt <= period_end ? '0 : period_cnt + CW'(1);
            sample_strobe <= period_end && fifo_in_ready;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            held <= '0;
        end else if (load_set) begin
            held <= fifo_out_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sample_ready_flag <= 1'b0;
            overrun <= 1'b0;
            axis_read <= 3'h0;
        end else begin
            axis_read <= next_axis_read;
            if (load_set) begin
                sample_ready_flag <= 1'b1;
                if (sample_ready_flag) begin
                    overrun <= 1'b1;
                end
            end else if (all_read) begin
                sample_ready_flag <= 1'b0;
                overrun <= 1'b0;
            end
        end
    end

    wire [7:0] status_word = (8'h01 << READY_POS) & {8{sample_ready_flag}}
                           | (8'h01 << OVERRUN_POS) & {8{overrun}};
    wire [7:0] next_rdata = (reg_addr == ADDR_CONTROL_ONE) ? control_one :
                            (reg_addr == ADDR_PIN_ROUTING) ? pin_routing_control :
                            (reg_addr == ADDR_SAMPLE_STATUS) ? status_word :
                            (reg_addr == ADDR_AXIS_X) ? held[0 +: SAMPLE_W] :
                            (reg_addr == ADDR_AXIS_Y) ? held[SAMPLE_W +: SAMPLE_W] :
                            (reg_addr == ADDR_AXIS_Z) ? held[2*SAMPLE_W +: SAMPLE_W] :
                            8'h00;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    event_pin_mux u_pin_a (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .code(pin_routing_control[PIN_A_LSB +: 3]),
        .ready(sample_ready_flag),
        .src_one(src_one),
        .src_two(src_two),
        .pin(event_pin_a)
    );
    event_pin_mux u_pin_b (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .code(pin_routing_control[PIN_B_LSB +: 3]),
        .ready(sample_ready_flag),
        .src_one(src_one),
        .src_two(src_two),
        .pin(event_pin_b)
    );

    // assertions
    property p_reset_rate;
        @(posedge sys_clk) $fell(sys_rst) |-> !rate_select_bit;
    endproperty
    a_reset_rate: assert property (p_reset_rate) else $error("rate bit not cleared");

    property p_period;
        @(posedge sys_clk) disable iff (sys_rst)
        (period_end && !wr_ctrl) |=> (period_cnt == '0);
    endproperty
    a_period: assert property (p_period) else $error("period counter did not wrap");

    sequence s_set_loaded;
        load_set;
    endsequence
    property p_ready_set;
        @(posedge sys_clk) disable iff (sys_rst) s_set_loaded |=> sample_ready_flag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_ready_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        (all_read && !load_set) |=> !sample_ready_flag;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

    property p_ready_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (sample_ready_flag && !all_read) |=> sample_ready_flag;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready fell early");

    property p_overrun;
        @(posedge sys_clk) disable iff (sys_rst)
        (load_set && sample_ready_flag) |=> overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");

    property p_status_bit;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_SAMPLE_STATUS) |=>
            (reg_rdata[READY_POS] == $past(sample_ready_flag));
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("status bit 3 wrong");

    property p_pin_ready;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_A_LSB +: 3] == PIN_FN_READY) |=>
            (event_pin_a == $past(sample_ready_flag));
    endproperty
    a_pin_ready: assert property (p_pin_ready) else $error("pin a not ready");

    property p_pin_or;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_B_LSB +: 3] == PIN_FN_SRC_OR) |=>
            (event_pin_b == ($past(src_one) | $past(src_two)));
    endproperty
    a_pin_or: assert property (p_pin_or) else $error("pin b not or");

    property p_pin_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_A_LSB +: 3] == 3'h0) |=> !event_pin_a;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin a not low");

    property p_pin_b_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_B_LSB +: 3] == 3'h0) |=> !event_pin_b;
    endproperty
    a_pin_b_idle: assert property (p_pin_b_idle) else $error("pin b not low");

    property p_pin_b_ready;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_B_LSB +: 3] == PIN_FN_READY) |=>
            (event_pin_b == $past(sample_ready_flag));
    endproperty
    a_pin_b_ready: assert property (p_pin_b_ready) else $error("pin b not ready");

    property p_pin_src_one;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_A_LSB +: 3] == PIN_FN_SRC_ONE) |=>
            (event_pin_a == $past(src_one));
    endproperty
    a_pin_src_one: assert property (p_pin_src_one) else $error("pin a not src one");

    property p_pin_src_two;
        @(posedge sys_clk) disable iff (sys_rst)
        (pin_routing_control[PIN_B_LSB +: 3] == PIN_FN_SRC_TWO) |=>
            (event_pin_b == $past(src_two));
    endproperty
    a_pin_src_two: assert property (p_pin_src_two) else $error("pin b not src two");

    // the strobe is a single-cycle pulse once per period
    property p_strobe_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        sample_strobe |=> !sample_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

    // an unread set is replaced by the newer one
    property p_overwrite;
        @(posedge sys_clk) disable iff (sys_rst)
        load_set |=> (held == $past(fifo_out_data));
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("set not replaced");

    // a rising ready edge only ever follows a fresh load
    property p_ready_fresh;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(sample_ready_flag) |-> $past(load_set);
    endproperty
    a_ready_fresh: assert property (p_ready_fresh) else $error("ready rose without data");

    sequence s_no_full_read;
        overrun && !all_read;
    endsequence
    property p_overrun_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        s_no_full_read |=> overrun;
    endproperty
    a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");

    property p_status_overrun;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_SAMPLE_STATUS) |=>
            (reg_rdata[OVERRUN_POS] == $past(overrun));
    endproperty
    a_status_overrun: assert property (p_status_overrun) else $error("status bit 7 wrong");
endmodule

// ---- verification/host_reader.sv ----
// host model: single-cycle register reads and writes on the device register port
// assumes read data is registered and valid the cycle after the read pulse
`timescale 1ns/1ns
module host_reader (
    // clock
    input wire logic sys_clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // idle address and data show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask

    // full set read of the three axis registers, issued at once without waiting for the ready edge
    task automatic read_set(output logic [23:0] s);
        rd(8'h29, s[7:0]);
        rd(8'h2b, s[15:8]);
        rd(8'h2d, s[23:16]);
    endtask
endmodule

// ---- verification/sample_rate_and_ready_pins_tb.sv ----
// self-checking bench for the sample-rate and sample-ready block
// assumes short periods of 80 and 20 cycles in place of the real ones
`timescale 1ns/1ns
module sample_rate_and_ready_pins_tb;
    import rate_ready_pkg::*;
    logic sys_clk, sys_rst, src_one, src_two, sample_strobe, event_pin_a, event_pin_b;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [23:0] sense_data, s;
    int err_count = 0;
    int check_count = 0;

    sample_rate_ready #(.PERIOD_SLOW(80), .PERIOD_FAST(20)) u_sample_rate_ready (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sense_data(sense_data),
        .unused_guard(24'h000000), .src_one(src_one), .src_two(src_two),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
        .event_pin_a(event_pin_a), .event_pin_b(event_pin_b));
    host_reader u_host_reader (
        .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // returns one cycle after a strobe, or counts a mismatch
    task automatic wait_strobe(output int n);
        n = 0;
        while (sample_strobe !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 1000) err_count++;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic test_reset();
        u_host_reader.rd(8'h20, v);
        check(v, 8'h07);
        u_host_reader.rd(8'h22, v);
        check(v, 8'h00);
        u_host_reader.rd(8'h30, v);
        check(v, 8'h00);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h08, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_rate();
        int n;
        wait_strobe(n);
        wait_strobe(n);
        check(8'(n + 1), 8'd80);
        u_host_reader.wr(8'h20, 8'h87);
        wait_strobe(n);
        wait_strobe(n);
        check(8'(n + 1), 8'd20);
        u_host_reader.wr(8'h20, 8'h07);
        $display("test rate done");
    endtask

    task automatic test_ready();
        int n;
        u_host_reader.read_set(s);
        wait_strobe(n);
        repeat (3) @(posedge sys_clk);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h88, 8'h08);
        u_host_reader.rd(8'h29, v);
        check(v, 8'h11);
        u_host_reader.rd(8'h2b, v);
        check(v, 8'h22);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h08, 8'h08);
        u_host_reader.rd(8'h2d, v);
        check(v, 8'h33);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h88, 8'h00);
        u_host_reader.wr(8'h20, 8'h01);
        wait_strobe(n);
        repeat (3) @(posedge sys_clk);
        u_host_reader.rd(8'h29, v);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h88, 8'h00);
        u_host_reader.wr(8'h20, 8'h07);
        $display("test ready done");
    endtask

    task automatic test_overrun();
        int n;
        wait_strobe(n);
        wait_strobe(n);
        repeat (3) @(posedge sys_clk);
        u_host_reader.rd(8'h27, v);
        check(v & 8'h88, 8'h88);
        $display("test overrun done");
    endtask

    // ready stays high here: the overrun test left the set unread
    function automatic logic pin_fn(input logic [2:0] c);
        case (c)
            PIN_FN_SRC_ONE: return src_one;
            PIN_FN_SRC_TWO: return src_two;
            PIN_FN_SRC_OR: return src_one | src_two;
            PIN_FN_READY: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic test_pins();
        for (int k = 0; k < 2; k++) begin
            src_one = (k == 0);
            src_two = (k == 1);
            for (int c = 0; c < 8; c++) begin
                u_host_reader.wr(8'h22, {2'b00, ~3'(c), 3'(c)});
                repeat (2) @(posedge sys_clk);
                #1;
                check({7'h00, event_pin_a}, {7'h00, pin_fn(3'(c))});
                check({7'h00, event_pin_b}, {7'h00, pin_fn(~3'(c))});
            end
        end
        $display("test pins done");
    endtask

    initial begin
        sys_rst = 1'b1;
        src_one = 1'b0;
        src_two = 1'b0;
        sense_data = 24'h332211;
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        test_reset();
        test_rate();
        test_ready();
        test_overrun();
        test_pins();
        stop_test();
    end

    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule
